// ===== rtl/cdip_map.svh
// Constants for the configuration data input port
//
// Summary of operation
// - Selected only while active-low select is Low and active-high select High.
// - Selected write strobe Low captures the byte bus into the buffer.
// - Selected read strobe Low drives status bit line: High ready, Low busy.
// - During a status read the lower seven lines are driven, inactive High.
// - Write and read strobes Low together: write done, read ignored.
// - Master parallel mode drives an 18-bit PROM address.
// - Master parallel and peripheral modes take data as bytes.
// - Serial modes sample one bit per rising configuration clock edge.
// - In byte modes the serial input pin is bit 0 of the bus.
// - Every mode except async peripheral presents serial data on the chain output.
// - Chain output changes on falling edge 1.5 periods after sampling.
// - Each primary global input drives its own global net, else user I/O.
// - Each secondary global net selects its pin or internal logic.
// - After configuration all configuration pins are released.
// - Unused outputs float (pulled up) before and during configuration; the chain output is still driven during configuration in async peripheral mode.
// - Configuration clock out in master and async peripheral, else input.
// - Peripheral modes drive ready/busy; async peripheral also on status bit line.
// - A data error pulls the open-drain clear/wait pin Low.
`ifndef CDIP_MAP_SVH
`define CDIP_MAP_SVH
`define CDIP_ADDR_W    18
`define CDIP_BYTE_W    8
`define CDIP_NGLB      4
`define CDIP_PIN_W     15
`define CDIP_MODE_MSER 3'h0
`define CDIP_MODE_MPAR 3'h4
`define CDIP_MODE_SPER 3'h3
`define CDIP_MODE_APER 3'h5
`define CDIP_MODE_SSER 3'h7
`define CDIP_CFGCLK_HALF 4'h3
`define CDIP_WAIT_CYC  4'h6
`define CDIP_LOW7_IDLE 7'h7f
`define CDIP_BIT_LAST  3'h7
`define CDIP_ADDR_ONE  18'h00001
`define CDIP_DIV_ONE   4'h1
`define CDIP_CNT_ONE   3'h1
`endif

// ===== rtl/cdip_pkg.sv
// Types shared by the configuration data input port modules
`include "cdip_map.svh"
package cdip_pkg;
	typedef enum logic [2:0] {
		CDIP_ST_WAIT = 3'h1,
		CDIP_ST_RUN  = 3'h2,
		CDIP_ST_DONE = 3'h4
	} cdip_state_t;

	typedef struct packed {
		cdip_state_t              state;
		logic [2:0]               mode;
		logic [3:0]               div;
		logic                     cfg_clk;
		logic                     pend;
		logic [`CDIP_BYTE_W-1:0]  data;
		logic [`CDIP_BYTE_W-1:0]  shift;
		logic [2:0]               cnt;
		logic                     chain0;
		logic                     chain1;
		logic                     dout;
		logic [`CDIP_ADDR_W-1:0]  addr;
		logic                     rd_oe;
		logic [`CDIP_BYTE_W-1:0]  rd_data;
		logic                     wr_prev;
		logic                     tgl_prev;
		logic                     err_low;
	} cdip_core_t;

	typedef struct packed {
		logic                     rs1;
		logic                     rs2;
		logic [1:0]               m1;
		logic [1:0]               m2;
		logic [`CDIP_BYTE_W-1:0]  shift;
		logic [2:0]               cnt;
		logic [`CDIP_BYTE_W-1:0]  data;
		logic                     tgl;
		logic                     chain0;
		logic                     chain1;
	} cdip_link_t;
endpackage : cdip_pkg

// ===== rtl/cdip_link_if.sv
// Signals between the core and the link-clock logic
`timescale 1ns/1ps
`include "cdip_map.svh"
interface cdip_link_if;
	logic [`CDIP_BYTE_W-1:0] byte_data;
	logic                    byte_tgl;
	logic                    chain_out;
	logic                    mode_sser;
	logic                    mode_sper;
	modport core (
		input  byte_data, byte_tgl, chain_out,
		output mode_sser, mode_sper
	);
	modport link (
		output byte_data, byte_tgl, chain_out,
		input  mode_sser, mode_sper
	);
endinterface : cdip_link_if

// ===== rtl/cdip_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cdip_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} cdip_sync_t;

	cdip_sync_t r_reg;
	cdip_sync_t r_next;

	always_comb begin
		r_next    = r_reg;
		r_next.s1 = din;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3) begin
			r_next.q = r_reg.s3;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.q;
endmodule : cdip_sync

// ===== rtl/cdip_link.sv
// Logic clocked by an external configuration clock
`timescale 1ns/1ps
`include "cdip_map.svh"
module cdip_link (
	input  wire logic                    config_clock,
	input  wire logic                    rst_b,
	input  wire logic                    serial_din,
	input  wire logic [`CDIP_BYTE_W-1:0] bus_in,
	input  wire logic                    select_active_low,
	input  wire logic                    select_active_high,
	input  wire logic                    write_strobe_low,
	cdip_link_if.link                    lk
);
	cdip_pkg::cdip_link_t r_reg;
	cdip_pkg::cdip_link_t r_next;
	logic                 dout_reg;
	logic                 sel;

	assign sel = !select_active_low && select_active_high;

	always_comb begin
		r_next     = r_reg;
		r_next.rs1 = rst_b;
		r_next.rs2 = r_reg.rs1;
		r_next.m1  = {lk.mode_sper, lk.mode_sser};
		r_next.m2  = r_reg.m1;
		if (!r_reg.rs2) begin
			r_next.shift  = '0;
			r_next.cnt    = '0;
			r_next.data   = '0;
			r_next.tgl    = 1'b0;
			r_next.chain0 = 1'b0;
			r_next.chain1 = 1'b0;
		end else begin
			r_next.chain0 = serial_din;
			r_next.chain1 = r_reg.chain0;
			if (r_reg.m2[0]) begin
				r_next.shift = {r_reg.shift[`CDIP_BYTE_W-2:0], serial_din};
				r_next.cnt   = r_reg.cnt + `CDIP_CNT_ONE;
				if (r_reg.cnt == `CDIP_BIT_LAST) begin
					r_next.data = r_next.shift;
					r_next.tgl  = !r_reg.tgl;
				end
			end else if (r_reg.m2[1] && sel && !write_strobe_low) begin
				r_next.data = bus_in;
				r_next.tgl  = !r_reg.tgl;
			end
		end
	end

	always_ff @(posedge config_clock) begin
		r_reg <= r_next;
	end

	// Chain output on the falling edge
	always_ff @(negedge config_clock) begin
		if (!r_reg.rs2) begin
			dout_reg <= 1'b0;
		end else begin
			dout_reg <= r_reg.chain1;
		end
	end

	assign lk.byte_data = r_reg.data;
	assign lk.byte_tgl  = r_reg.tgl;
	assign lk.chain_out = dout_reg;
endmodule : cdip_link

// ===== rtl/cdip_top.sv
// Configuration data input port, device side
`timescale 1ns/1ps
`include "cdip_map.svh"
module cdip_top (
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	input  wire logic                    config_clock,
	input  wire logic [2:0]              mode_pins,
	input  wire logic                    select_active_low,
	input  wire logic                    select_active_high,
	input  wire logic                    write_strobe_low,
	input  wire logic                    read_strobe_low,
	input  wire logic [`CDIP_BYTE_W-1:0] config_byte_bus_in,
	output logic      [`CDIP_BYTE_W-1:0] config_byte_bus_out,
	output logic                         config_byte_bus_oe,
	output logic      [`CDIP_ADDR_W-1:0] prom_address_out,
	output logic                         prom_address_oe,
	output logic                         config_clock_out,
	output logic                         config_clock_oe,
	input  wire logic                    serial_din,
	output logic                         serial_dout,
	output logic                         serial_dout_oe,
	output logic                         ready_busy_out,
	output logic                         ready_busy_oe,
	output logic                         clear_wait_out,
	output logic                         clear_wait_oe,
	input  wire logic                    config_done,
	input  wire logic                    data_error,
	output logic      [`CDIP_BYTE_W-1:0] cfg_byte_data,
	output logic                         cfg_byte_valid,
	input  wire logic                    cfg_byte_ready,
	input  wire logic [`CDIP_NGLB-1:0]   primary_global_inputs,
	input  wire logic [`CDIP_NGLB-1:0]   primary_global_en,
	output logic      [`CDIP_NGLB-1:0]   primary_global_nets,
	output logic      [`CDIP_NGLB-1:0]   primary_user_in,
	input  wire logic [`CDIP_NGLB-1:0]   secondary_global_inputs,
	input  wire logic [`CDIP_NGLB-1:0]   secondary_global_sel,
	input  wire logic [`CDIP_NGLB-1:0]   secondary_global_logic,
	output logic      [`CDIP_NGLB-1:0]   secondary_global_nets,
	output logic                         config_active
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cdip_pkg::cdip_core_t    r_reg;
	cdip_pkg::cdip_core_t    r_next;
	logic [`CDIP_PIN_W-1:0]  pin_raw;
	logic [`CDIP_PIN_W-1:0]  pin_s;
	logic [2:0]              mode_s;
	logic                    sel_low_s;
	logic                    sel_high_s;
	logic                    wstb_low_s;
	logic                    rstb_low_s;
	logic                    din_s;
	logic [`CDIP_BYTE_W-1:0] bus_s;
	logic                    tgl_s;
	logic                    running;
	logic                    sel;
	logic                    wr;
	logic                    m_mser;
	logic                    m_mpar;
	logic                    m_aper;
	logic                    m_sper;
	logic                    m_sser;

	cdip_link_if lk ();

	function automatic logic mode_is(
		input logic [2:0] mode,
		input logic [2:0] code
	);
		mode_is = (mode == code);
	endfunction : mode_is

	// ----------------------------------------------------------------
	// Pin synchronisers and link-clock logic
	// ----------------------------------------------------------------
	assign pin_raw = {mode_pins, select_active_low, select_active_high,
		write_strobe_low, read_strobe_low, serial_din,
		config_byte_bus_in[`CDIP_BYTE_W-1:1]};

	cdip_sync #(.W(`CDIP_PIN_W)) u_pin_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   (pin_raw),
		.dout  (pin_s)
	);

	cdip_sync #(.W(1)) u_tgl_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   (lk.byte_tgl),
		.dout  (tgl_s)
	);

	cdip_link u_link (
		.config_clock       (config_clock),
		.rst_b              (rst_b),
		.serial_din         (serial_din),
		.bus_in             ({config_byte_bus_in[`CDIP_BYTE_W-1:1],
			serial_din}),
		.select_active_low  (select_active_low),
		.select_active_high (select_active_high),
		.write_strobe_low   (write_strobe_low),
		.lk                 (lk.link)
	);

	// Serial input doubles as bit 0 of the byte bus
	assign {mode_s, sel_low_s, sel_high_s, wstb_low_s, rstb_low_s, din_s} =
		pin_s[`CDIP_PIN_W-1:`CDIP_BYTE_W-1];
	assign bus_s = {pin_s[`CDIP_BYTE_W-2:0], din_s};

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	assign m_mser  = mode_is(r_reg.mode, `CDIP_MODE_MSER);
	assign m_mpar  = mode_is(r_reg.mode, `CDIP_MODE_MPAR);
	assign m_aper  = mode_is(r_reg.mode, `CDIP_MODE_APER);
	assign m_sper  = mode_is(r_reg.mode, `CDIP_MODE_SPER);
	assign m_sser  = mode_is(r_reg.mode, `CDIP_MODE_SSER);
	assign running = (r_reg.state == cdip_pkg::CDIP_ST_RUN);
	assign sel     = !sel_low_s && sel_high_s;
	assign wr      = sel && !wstb_low_s;

	assign lk.mode_sser = running && m_sser;
	assign lk.mode_sper = running && m_sper;

	// ----------------------------------------------------------------
	// Core state
	// ----------------------------------------------------------------
	always_comb begin
		r_next  = r_reg;
		r_next.rd_oe = 1'b0;
		case (r_reg.state)
		cdip_pkg::CDIP_ST_WAIT: begin
			r_next.div = r_reg.div + `CDIP_DIV_ONE;
			if (r_reg.div == `CDIP_WAIT_CYC) begin
				r_next.mode  = mode_s;
				r_next.div   = '0;
				r_next.state = cdip_pkg::CDIP_ST_RUN;
			end
		end
		cdip_pkg::CDIP_ST_RUN: begin
			// Handover clear first so a new capture wins
			if (r_reg.pend && cfg_byte_ready) begin
				r_next.pend = 1'b0;
			end
			// Generated clock, held low while a byte waits, except in async peripheral mode
			if ((m_mser || m_mpar || m_aper) &&
				(r_reg.cfg_clk || !r_reg.pend || m_aper)) begin
				r_next.div = r_reg.div + `CDIP_DIV_ONE;
				if (r_reg.div == `CDIP_CFGCLK_HALF) begin
					r_next.div     = '0;
					r_next.cfg_clk = !r_reg.cfg_clk;
					if (!r_reg.cfg_clk && m_mser) begin
						r_next.shift = {r_reg.shift[`CDIP_BYTE_W-2:0],
							din_s};
						r_next.cnt   = r_reg.cnt + `CDIP_CNT_ONE;
						if (r_reg.cnt == `CDIP_BIT_LAST) begin
							r_next.data = r_next.shift;
							r_next.pend = 1'b1;
						end
					end
					if (!r_reg.cfg_clk && m_mpar) begin
						r_next.data = bus_s;
						r_next.pend = 1'b1;
					end
					if (!r_reg.cfg_clk && (m_mser || m_mpar)) begin
						r_next.chain0 = din_s;
						r_next.chain1 = r_reg.chain0;
					end
					if (r_reg.cfg_clk) begin
						r_next.dout = r_reg.chain1;
					end
				end
			end
			// Address steps once the fetched byte is handed on
			if (m_mpar && r_reg.pend && cfg_byte_ready) begin
				r_next.addr = r_reg.addr + `CDIP_ADDR_ONE;
			end
			// Asynchronous peripheral write and status read
			if (m_aper) begin
				r_next.wr_prev = wr;
				// A write while busy is refused
				if (wr && !r_reg.wr_prev && !r_reg.pend) begin
					r_next.data = bus_s;
					r_next.pend = 1'b1;
				end
				if (sel && !rstb_low_s && !wr) begin
					r_next.rd_oe   = 1'b1;
					r_next.rd_data = {!r_next.pend,
						`CDIP_LOW7_IDLE};
				end
			end
			// Bytes gathered on the external clock
			if (m_sser || m_sper) begin
				r_next.tgl_prev = tgl_s;
				if (tgl_s != r_reg.tgl_prev) begin
					r_next.data = lk.byte_data;
					r_next.pend = 1'b1;
				end
			end
			if (data_error) begin
				r_next.err_low = 1'b1;
			end
			if (config_done) begin
				r_next.state = cdip_pkg::CDIP_ST_DONE;
			end
		end
		cdip_pkg::CDIP_ST_DONE: begin
			r_next.pend = 1'b0;
		end
		default: begin
			r_next.state = cdip_pkg::CDIP_ST_WAIT;
		end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r_reg       <= '0;
			r_reg.state <= cdip_pkg::CDIP_ST_WAIT;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers, released outside configuration
	// ----------------------------------------------------------------
	assign config_active       = running;
	assign config_byte_bus_out = r_reg.rd_data;
	assign config_byte_bus_oe  = running && r_reg.rd_oe;
	assign prom_address_out    = r_reg.addr;
	assign prom_address_oe     = running && m_mpar;
	assign config_clock_out    = r_reg.cfg_clk;
	assign config_clock_oe     = running &&
		(m_mser || m_mpar || m_aper);
	assign serial_dout         = (m_sser || m_sper) ? lk.chain_out :
		r_reg.dout;
	assign serial_dout_oe      = running;
	assign ready_busy_out      = !r_reg.pend;
	assign ready_busy_oe       = running && (m_aper || m_sper);
	assign clear_wait_out      = 1'b0;
	assign clear_wait_oe       = running && r_reg.err_low;
	assign cfg_byte_data       = r_reg.data;
	assign cfg_byte_valid      = r_reg.pend;

	// ----------------------------------------------------------------
	// Global nets
	// ----------------------------------------------------------------
	assign primary_global_nets   = primary_global_inputs &
		primary_global_en;
	assign primary_user_in       = primary_global_inputs &
		~primary_global_en;
	assign secondary_global_nets = (secondary_global_sel &
		secondary_global_logic) | (~secondary_global_sel &
		secondary_global_inputs);
endmodule : cdip_top

// ===== tb/cdip_top_sva.sv
// Concurrent checks on the configuration data input port
`timescale 1ns/1ps
`include "cdip_map.svh"
module cdip_top_sva (
	input wire logic                    mclk,
	input wire logic                    rst_b,
	input wire logic                    read_strobe_low,
	input wire logic                    write_strobe_low,
	input wire logic [`CDIP_BYTE_W-1:0] config_byte_bus_out,
	input wire logic                    config_byte_bus_oe,
	input wire logic                    ready_busy_out,
	input wire logic                    ready_busy_oe,
	input wire logic [`CDIP_BYTE_W-1:0] cfg_byte_data,
	input wire logic                    cfg_byte_valid,
	input wire logic                    cfg_byte_ready,
	input wire logic [`CDIP_NGLB-1:0]   primary_global_inputs,
	input wire logic [`CDIP_NGLB-1:0]   primary_global_en,
	input wire logic [`CDIP_NGLB-1:0]   primary_global_nets,
	input wire logic [`CDIP_NGLB-1:0]   secondary_global_inputs,
	input wire logic [`CDIP_NGLB-1:0]   secondary_global_sel,
	input wire logic [`CDIP_NGLB-1:0]   secondary_global_logic,
	input wire logic [`CDIP_NGLB-1:0]   secondary_global_nets,
	input wire logic                    config_done,
	input wire logic                    data_error,
	input wire logic                    clear_wait_oe,
	input wire logic                    config_active,
	input wire logic                    prom_address_oe,
	input wire logic                    config_clock_oe,
	input wire logic                    serial_dout_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_status_cause: assert property ($rose(config_byte_bus_oe) |->
		$past(read_strobe_low, 3) == 1'b0 && $past(write_strobe_low, 3))
		else $error("status drive without a lone read");
	a_status_low7: assert property (config_byte_bus_oe |->
		config_byte_bus_out[6:0] == 7'h7f)
		else $error("lower status lines not inactive");
	a_busy_valid: assert property (ready_busy_oe |->
		ready_busy_out == !cfg_byte_valid)
		else $error("ready flag disagrees with pending byte");
	a_valid_holds: assert property (cfg_byte_valid && !cfg_byte_ready |=>
		cfg_byte_valid && $stable(cfg_byte_data))
		else $error("pending byte lost before handoff");
	a_valid_drops: assert property (cfg_byte_valid && cfg_byte_ready |=>
		!cfg_byte_valid)
		else $error("byte still pending after handoff");
	a_primary_nets: assert property (primary_global_nets ==
		(primary_global_inputs & primary_global_en))
		else $error("primary net wrong");
	a_secondary_nets: assert property (secondary_global_nets ==
		((secondary_global_sel & secondary_global_logic) |
		(~secondary_global_sel & secondary_global_inputs)))
		else $error("secondary net wrong");
	a_idle_float: assert property (!config_active |-> !(config_byte_bus_oe ||
		prom_address_oe || config_clock_oe || serial_dout_oe || ready_busy_oe))
		else $error("pin driven outside configuration");
	a_done_release: assert property (config_done [*6] |-> !config_active)
		else $error("configuration not ended");
	a_error_pull: assert property ((config_active && data_error) [*6] |->
		clear_wait_oe)
		else $error("error not reported");
	c_handoff: cover property (cfg_byte_valid && cfg_byte_ready);
	c_status: cover property (config_byte_bus_oe);
	c_error: cover property (clear_wait_oe);
	c_fetch: cover property (prom_address_oe && cfg_byte_valid);
endmodule : cdip_top_sva

bind cdip_top cdip_top_sva chk_u (.*);

// ===== tb/cdip_up_model.sv
// Upstream serial device feeding the chain input
`timescale 1ns/1ps
module cdip_up_model (
	output logic        config_clock,
	output logic        p_din,
	output int          rises,
	output logic [15:0] sent
);
	initial begin
		config_clock = 1'b0;
		p_din = 1'b1;
		rises = 0;
		sent = 16'h0000;
	end
	// Clock edges with data held, used around reset
	task pulse(input int n);
		rises = 0;
		repeat (n) begin
			#15 config_clock = 1'b1;
			#15 config_clock = 1'b0;
		end
	endtask : pulse
	// One frame, clock still before and after
	task send(input logic [15:0] v);
		sent = v;
		rises = 0;
		#7;
		for (int i = 15; i >= 0; i--) begin
			p_din = v[i];
			#15 config_clock = 1'b1;
			rises++;
			#15 config_clock = 1'b0;
		end
		p_din = ~v[0];
	endtask : send
endmodule : cdip_up_model

// ===== tb/test_config_data_input_port.sv
// Bench for the configuration data input port
`timescale 1ns/1ps
`include "cdip_map.svh"
`define CDIP_CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	miscompares++; $display("mismatch at %0t got %h exp %h", \
	$time, (a), (b)); end end
`define CDIP_WAIT(s, v) for (n = 0; n < 40 && (s) !== (v); n++) begin \
	@(posedge mclk); #1; end
module test_config_data_input_port;
	logic        mclk, rst_b, config_clock, serial_din, tb_din, p_din, use_p;
	logic        select_active_low, select_active_high;
	logic        write_strobe_low, read_strobe_low;
	logic        config_byte_bus_oe, prom_address_oe, config_clock_out;
	logic        config_clock_oe, serial_dout, serial_dout_oe;
	logic        ready_busy_out, ready_busy_oe, clear_wait_out, clear_wait_oe;
	logic        config_done, data_error, cfg_byte_valid, cfg_byte_ready;
	logic        config_active;
	logic [2:0]  mode_pins;
	logic [7:0]  config_byte_bus_in, config_byte_bus_out, cfg_byte_data;
	logic [17:0] prom_address_out, addr_seen;
	logic [3:0]  primary_global_inputs, primary_global_en;
	logic [3:0]  primary_global_nets, primary_user_in;
	logic [3:0]  secondary_global_inputs, secondary_global_sel;
	logic [3:0]  secondary_global_logic, secondary_global_nets;
	logic [15:0] sent;
	logic [7:0]  got[$];
	int          rises, n, miscompares, num_checks;

	assign serial_din = use_p ? p_din : tb_din;
	cdip_top dut_u (.*);
	cdip_up_model up_u (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (cfg_byte_valid && cfg_byte_ready)
		got.push_back(cfg_byte_data);
	always @(negedge config_clock) if (use_p && rises >= 2) begin
		#1;
		`CDIP_CHK(serial_dout, sent[17 - rises])
		`CDIP_CHK(serial_dout_oe, 1'b1)
	end
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task do_reset(input logic [2:0] m);
		@(posedge mclk);
		rst_b <= 1'b0;
		mode_pins <= m;
		up_u.pulse(4);
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (15) @(posedge mclk);
		up_u.pulse(2);
	endtask : do_reset
	// Bus bit 0 opposite to the serial pin, which stands for it
	task strobe(input logic sel, w, r, input logic [7:0] v);
		@(posedge mclk);
		select_active_low <= 1'b0;
		select_active_high <= sel;
		write_strobe_low <= w;
		read_strobe_low <= r;
		config_byte_bus_in <= v ^ 8'h01;
		tb_din <= v[0];
	endtask : strobe
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_globals;
		@(posedge mclk);
		primary_global_inputs <= 4'ha;
		primary_global_en <= 4'h6;
		secondary_global_inputs <= 4'h5;
		secondary_global_sel <= 4'h3;
		secondary_global_logic <= 4'ha;
		@(posedge mclk);
		#1;
		`CDIP_CHK(primary_global_nets, 4'h2)
		`CDIP_CHK(primary_user_in, 4'h8)
		`CDIP_CHK(secondary_global_nets, 4'h6)
	endtask : t_globals
	task t_async;
		do_reset(`CDIP_MODE_APER);
		#1;
		`CDIP_CHK(ready_busy_oe, 1'b1)
		strobe(1'b0, 1'b0, 1'b1, 8'ha5);
		repeat (10) @(posedge mclk);
		#1;
		`CDIP_CHK(cfg_byte_valid, 1'b0)
		strobe(1'b1, 1'b0, 1'b1, 8'ha5);
		`CDIP_WAIT(cfg_byte_valid, 1'b1)
		`CDIP_CHK(cfg_byte_valid, 1'b1)
		`CDIP_CHK(cfg_byte_data, 8'ha5)
		`CDIP_CHK(ready_busy_out, 1'b0)
		strobe(1'b1, 1'b1, 1'b1, 8'h00);
		repeat (6) @(posedge mclk);
		strobe(1'b1, 1'b1, 1'b0, 8'h00);
		`CDIP_WAIT(config_byte_bus_oe, 1'b1)
		`CDIP_CHK(config_byte_bus_out, 8'h7f)
		strobe(1'b1, 1'b1, 1'b1, 8'h00);
		repeat (6) @(posedge mclk);
		strobe(1'b1, 1'b0, 1'b1, 8'h11);
		repeat (8) @(posedge mclk);
		#1;
		`CDIP_CHK(cfg_byte_data, 8'ha5)
		strobe(1'b1, 1'b1, 1'b1, 8'h00);
		repeat (6) @(posedge mclk);
		cfg_byte_ready <= 1'b1;
		@(posedge mclk);
		cfg_byte_ready <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		`CDIP_CHK(ready_busy_out, 1'b1)
		strobe(1'b1, 1'b1, 1'b0, 8'h00);
		`CDIP_WAIT(config_byte_bus_oe, 1'b1)
		`CDIP_CHK(config_byte_bus_out, 8'hff)
		strobe(1'b1, 1'b1, 1'b1, 8'h00);
		repeat (6) @(posedge mclk);
		strobe(1'b1, 1'b0, 1'b0, 8'h3c);
		`CDIP_WAIT(cfg_byte_valid, 1'b1)
		`CDIP_CHK(cfg_byte_data, 8'h3c)
		repeat (4) @(posedge mclk);
		#1;
		`CDIP_CHK(config_byte_bus_oe, 1'b0)
		strobe(1'b0, 1'b1, 1'b1, 8'h00);
	endtask : t_async
	task t_mpar;
		@(posedge mclk);
		cfg_byte_ready <= 1'b1;
		config_byte_bus_in <= 8'h5b;
		tb_din <= 1'b0;
		do_reset(`CDIP_MODE_MPAR);
		#1;
		`CDIP_CHK(prom_address_oe, 1'b1)
		`CDIP_CHK(config_clock_oe, 1'b1)
		`CDIP_CHK(ready_busy_oe, 1'b0)
		`CDIP_WAIT(cfg_byte_valid, 1'b1)
		`CDIP_CHK(cfg_byte_data, 8'h5a)
		addr_seen = prom_address_out;
		@(posedge mclk);
		#1;
		`CDIP_CHK(prom_address_out, addr_seen + 18'h00001)
		@(posedge mclk);
		cfg_byte_ready <= 1'b0;
		`CDIP_WAIT(cfg_byte_valid, 1'b1)
		repeat (12) @(posedge mclk);
		#1;
		`CDIP_CHK(cfg_byte_valid, 1'b1)
		`CDIP_CHK(config_clock_out, 1'b0)
		`CDIP_CHK(prom_address_out, addr_seen + 18'h00001)
	endtask : t_mpar
	task t_serial;
		@(posedge mclk);
		use_p <= 1'b1;
		cfg_byte_ready <= 1'b1;
		do_reset(`CDIP_MODE_SSER);
		got.delete();
		up_u.send(16'ha53c);
		repeat (12) @(posedge mclk);
		#1;
		`CDIP_CHK(got.size(), 2)
		`CDIP_CHK(got[0], 8'ha5)
		`CDIP_CHK(got[1], 8'h3c)
		data_error <= 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		`CDIP_CHK(clear_wait_oe, 1'b1)
		`CDIP_CHK(clear_wait_out, 1'b0)
		data_error <= 1'b0;
		config_done <= 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		`CDIP_CHK(config_active, 1'b0)
		`CDIP_CHK(serial_dout_oe, 1'b0)
	endtask : t_serial
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end
	initial begin
		{rst_b, use_p, tb_din, config_done, data_error} = 5'h00;
		{select_active_low, select_active_high} = 2'h2;
		{write_strobe_low, read_strobe_low, cfg_byte_ready} = 3'h6;
		mode_pins = 3'h0;
		config_byte_bus_in = 8'h00;
		{primary_global_inputs, primary_global_en} = 8'h00;
		{secondary_global_inputs, secondary_global_sel} = 8'h00;
		secondary_global_logic = 4'h0;
		{miscompares, num_checks} = 0;
		t_globals();
		t_async();
		t_mpar();
		t_serial();
		wrap_up();
	end
endmodule : test_config_data_input_port
